// file: csf_alu_flags.v
// flag computation from one alu result
`timescale 1ns/10ps
module csf_alu_flags (
  input wire [15:0] result_i,
  input wire carry_out_i,
  input wire op_a_sign_i,
  input wire op_b_sign_i,
  input wire is_sub_i,
  output wire neg_o,
  output wire wrap_o,
  output wire zero_o,
  output wire carry_o
);
  wire eff_b_sign;
  assign eff_b_sign = op_b_sign_i ^ is_sub_i;
  assign neg_o = result_i[15];
  // operands agree in sign, result disagrees
  assign wrap_o = (op_a_sign_i == eff_b_sign) && (result_i[15] != op_a_sign_i);
  assign zero_o = (result_i == 16'h0000);
  assign carry_o = carry_out_i;
endmodule // csf_alu_flags

// file: csf_alu_model.sv
// alu side model feeding results and affect enables
`timescale 1ns/10ps
module csf_alu_model (
  input wire clk_sys_i,
  input wire go_i,
  input wire [15:0] a_i,
  input wire [15:0] b_i,
  input wire sub_i,
  input wire [3:0] aff_i,
  output reg valid_o = 1'b0,
  output reg [15:0] result_o,
  output reg carry_o,
  output reg a_sign_o,
  output reg b_sign_o,
  output reg sub_o,
  output reg [3:0] upd_o
);
  // ****
  // one result per go, junk while idle
  // ****
  wire [16:0] sum = {1'b0, a_i} + {1'b0, sub_i ? ~b_i : b_i} + {16'h0000, sub_i};
  always @(posedge clk_sys_i) begin
    valid_o <= go_i;
    upd_o <= aff_i;
    a_sign_o <= a_i[15];
    b_sign_o <= b_i[15];
    sub_o <= sub_i;
    if (go_i) begin
      {carry_o, result_o} <= sum;
    end else begin
      result_o <= ~result_o;
    end
  end
endmodule // csf_alu_model

// file: csf_chk.sv
// checker for the status flag block
`timescale 1ns/10ps
module csf_chk (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire alu_valid_i,
  input wire [15:0] alu_result_i,
  input wire alu_carry_i,
  input wire alu_a_sign_i,
  input wire alu_b_sign_i,
  input wire alu_sub_i,
  input wire upd_neg_i,
  input wire upd_wrap_i,
  input wire upd_zero_i,
  input wire upd_carry_i,
  input wire repeat_active_i,
  input wire clip_a_set_i,
  input wire clip_b_set_i,
  input wire pri_load_i,
  input wire [2:0] pri_load_val_i,
  input wire [3:0] cpu_level_o,
  input wire user_irq_off_o,
  input wire [15:0] cpu_status_flags_o
);
  // ****
  // shadow of lock and upper level bit
  // ****
  wire [15:0] s = cpu_status_flags_o;
  wire sw = wr_i && addr_i == 4'h0;
  wire az = alu_valid_i && upd_zero_i;
  wire wexp = (alu_a_sign_i ^ alu_result_i[15]) && (alu_b_sign_i ^ alu_sub_i ^ alu_result_i[15]);
  reg lk;
  reg cu;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      lk <= 1'b0;
      cu <= 1'b0;
    end else begin
      if (wr_i && addr_i == 4'h2) lk <= wdata_i[15];
      if (wr_i && addr_i == 4'h1) cu <= wdata_i[3];
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  AST_LEVEL: assert property (cpu_level_o == {cu, s[7:5]} && user_irq_off_o == &s[7:5]) else $error("lvl");
  AST_LOCK: assert property (sw && lk && !pri_load_i |=> s[7:5] == $past(s[7:5])) else $error("lock");
  AST_CLIP: assert property (sw && !wdata_i[9] && !clip_a_set_i && !clip_b_set_i |=>
    s[11:10] == $past(wdata_i[11:10])) else $error("clip");
  AST_REP: assert property (1'b1 |=> s[4] == $past(repeat_active_i)) else $error("rep");
  AST_NEG: assert property (alu_valid_i && upd_neg_i |=> s[3] == $past(alu_result_i[15])) else $error("neg");
  AST_ZERO: assert property (az |=> s[1] == ($past(alu_result_i) == 16'h0000)) else $error("zero");
  AST_CARRY: assert property (alu_valid_i && upd_carry_i |=> s[0] == $past(alu_carry_i)) else $error("cy");
  AST_HOLDZ: assert property (!az && !sw |=> $stable(s[1])) else $error("zhold");
  AST_WRAP: assert property (alu_valid_i && upd_wrap_i |=> s[2] == $past(wexp)) else $error("wrap");
  AST_HOLDC: assert property (!(alu_valid_i && upd_carry_i) && !sw |=> $stable(s[0])) else $error("chold");
  AST_PRI: assert property (pri_load_i |=> s[7:5] == $past(pri_load_val_i)) else $error("pri");
  cover property (sw && lk);
  cover property (az && alu_result_i == 16'h0000);
  cover property (clip_a_set_i);
  cover property (pri_load_i && lk);
endmodule // csf_chk

bind csf_status_flags csf_chk csf_chk_inst (.*);

// file: csf_regs.vh
// register map and field constants for the cpu status flag block
`ifndef CSF_REGS_VH
`define CSF_REGS_VH

`define CSF_ADDR_W 4
`define CSF_ADDR_STATUS 4'h0
`define CSF_ADDR_CTRL 4'h1
`define CSF_ADDR_INTCON 4'h2

`define CSF_STATUS_RESET 16'h0000
`define CSF_CTRL_RESET 16'h0000
`define CSF_INTCON_RESET 16'h0000

`define CSF_BIT_ACCA_CLIP 11
`define CSF_BIT_ACCB_CLIP 10
`define CSF_BIT_COMB_CLIP 9
`define CSF_PRI_HI 7
`define CSF_PRI_LO 5
`define CSF_BIT_REPEAT 4
`define CSF_BIT_NEG 3
`define CSF_BIT_WRAP 2
`define CSF_BIT_ZERO 1
`define CSF_BIT_CARRY 0

`define CSF_BIT_PRI_UPPER 3
`define CSF_BIT_NEST_DIS 15

`define CSF_PRI_TOP 3'h7
`define CSF_READ_NONE 16'h0000

`endif

// file: csf_status_flags.v
// cpu status flag register with software port
`timescale 1ns/10ps
`include "csf_regs.vh"
module csf_status_flags (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [`CSF_ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire alu_valid_i,
  input wire [15:0] alu_result_i,
  input wire alu_carry_i,
  input wire alu_a_sign_i,
  input wire alu_b_sign_i,
  input wire alu_sub_i,
  input wire upd_neg_i,
  input wire upd_wrap_i,
  input wire upd_zero_i,
  input wire upd_carry_i,
  input wire repeat_active_i,
  input wire clip_a_set_i,
  input wire clip_b_set_i,
  input wire pri_load_i,
  input wire [2:0] pri_load_val_i,
  output wire [3:0] cpu_level_o,
  output wire user_irq_off_o,
  output wire [15:0] cpu_status_flags_o
);
  // ****************************************
  // state
  // ****************************************
  reg [2:0] cpu_priority_field;
  reg neg_flag;
  reg signed_wrap_flag;
  reg zero_flag;
  reg carry_flag;
  reg acc_a_clip_flag;
  reg acc_b_clip_flag;
  reg repeat_flag;
  reg [15:0] core_control_reg;
  reg [15:0] interrupt_control_one;
  wire priority_upper_bit;
  wire nesting_disable_bit;
  wire combined_clip_flag;
  wire f_neg;
  wire f_wrap;
  wire f_zero;
  wire f_carry;
  wire wr_status;
  reg [15:0] status_word;
  reg [15:0] next_core_ctrl;
  reg [15:0] next_intcon;
  reg [2:0] next_priority;
  reg next_neg;
  reg next_wrap;
  reg next_zero;
  reg next_carry;
  reg next_clip_a;
  reg next_clip_b;
  reg [15:0] next_rdata;
  wire alu_neg_upd;
  wire alu_wrap_upd;
  wire alu_zero_upd;
  wire alu_carry_upd;
  wire pri_write_ok;

  localparam [15:0] STATUS_RST = `CSF_STATUS_RESET;

  // ****************************************
  // decode helpers
  // ****************************************
  function field_sel;
    input [`CSF_ADDR_W-1:0] a;
    input [`CSF_ADDR_W-1:0] target;
    begin
      field_sel = (a == target);
    end
  endfunction

  function alu_takes;
    input valid;
    input enable;
    begin
      alu_takes = valid && enable;
    end
  endfunction

  assign priority_upper_bit = core_control_reg[`CSF_BIT_PRI_UPPER];
  assign nesting_disable_bit = interrupt_control_one[`CSF_BIT_NEST_DIS];
  assign combined_clip_flag = acc_a_clip_flag | acc_b_clip_flag;
  assign wr_status = wr_i && field_sel(addr_i, `CSF_ADDR_STATUS);
  assign pri_write_ok = wr_status && !nesting_disable_bit;

  // ****************************************
  // alu update qualifiers
  // ****************************************
  assign alu_neg_upd = alu_takes(alu_valid_i, upd_neg_i);
  assign alu_wrap_upd = alu_takes(alu_valid_i, upd_wrap_i);
  assign alu_zero_upd = alu_takes(alu_valid_i, upd_zero_i);
  assign alu_carry_upd = alu_takes(alu_valid_i, upd_carry_i);

  csf_alu_flags u_flags (
    .result_i(alu_result_i),
    .carry_out_i(alu_carry_i),
    .op_a_sign_i(alu_a_sign_i),
    .op_b_sign_i(alu_b_sign_i),
    .is_sub_i(alu_sub_i),
    .neg_o(f_neg),
    .wrap_o(f_wrap),
    .zero_o(f_zero),
    .carry_o(f_carry)
  );

  // ****************************************
  // status word assembly
  // ****************************************
  always @* begin
    status_word = 16'h0000;
    status_word[`CSF_BIT_ACCA_CLIP] = acc_a_clip_flag;
    status_word[`CSF_BIT_ACCB_CLIP] = acc_b_clip_flag;
    status_word[`CSF_BIT_COMB_CLIP] = combined_clip_flag;
    status_word[`CSF_PRI_HI:`CSF_PRI_LO] = cpu_priority_field;
    status_word[`CSF_BIT_REPEAT] = repeat_flag;
    status_word[`CSF_BIT_NEG] = neg_flag;
    status_word[`CSF_BIT_WRAP] = signed_wrap_flag;
    status_word[`CSF_BIT_ZERO] = zero_flag;
    status_word[`CSF_BIT_CARRY] = carry_flag;
  end

  // ****************************************
  // status and level outputs
  // ****************************************
  assign cpu_status_flags_o = status_word;
  assign cpu_level_o = {priority_upper_bit, cpu_priority_field};
  assign user_irq_off_o = (cpu_priority_field == `CSF_PRI_TOP);

  // ****************************************
  // control registers
  // ****************************************
  always @* begin
    next_core_ctrl = core_control_reg;
    next_intcon = interrupt_control_one;
    if (wr_i && field_sel(addr_i, `CSF_ADDR_CTRL)) begin
      next_core_ctrl = wdata_i;
    end
    if (wr_i && field_sel(addr_i, `CSF_ADDR_INTCON)) begin
      next_intcon = wdata_i;
    end
  end

  // ****************************************
  // control register state
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      core_control_reg <= `CSF_CTRL_RESET;
      interrupt_control_one <= `CSF_INTCON_RESET;
    end else begin
      core_control_reg <= next_core_ctrl;
      interrupt_control_one <= next_intcon;
    end
  end

  // ****************************************
  // priority field next value
  // ****************************************
  always @* begin
    next_priority = cpu_priority_field;
    if (pri_load_i) begin
      next_priority = pri_load_val_i;
    end else if (pri_write_ok) begin
      next_priority = wdata_i[`CSF_PRI_HI:`CSF_PRI_LO];
    end
  end

  // ****************************************
  // priority and repeat state
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      cpu_priority_field <= STATUS_RST[`CSF_PRI_HI:`CSF_PRI_LO];
      repeat_flag <= STATUS_RST[`CSF_BIT_REPEAT];
    end else begin
      cpu_priority_field <= next_priority;
      repeat_flag <= repeat_active_i;
    end
  end

  // ****************************************
  // alu flags
  // ****************************************
  // alu update beats software write, flag by flag
  always @* begin
    next_neg = neg_flag;
    next_wrap = signed_wrap_flag;
    next_zero = zero_flag;
    next_carry = carry_flag;
    if (alu_neg_upd) begin
      next_neg = f_neg;
    end else if (wr_status) begin
      next_neg = wdata_i[`CSF_BIT_NEG];
    end
    if (alu_wrap_upd) begin
      next_wrap = f_wrap;
    end else if (wr_status) begin
      next_wrap = wdata_i[`CSF_BIT_WRAP];
    end
    if (alu_zero_upd) begin
      next_zero = f_zero;
    end else if (wr_status) begin
      next_zero = wdata_i[`CSF_BIT_ZERO];
    end
    if (alu_carry_upd) begin
      next_carry = f_carry;
    end else if (wr_status) begin
      next_carry = wdata_i[`CSF_BIT_CARRY];
    end
  end

  // ****************************************
  // alu flag state
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      neg_flag <= STATUS_RST[`CSF_BIT_NEG];
      signed_wrap_flag <= STATUS_RST[`CSF_BIT_WRAP];
      zero_flag <= STATUS_RST[`CSF_BIT_ZERO];
      carry_flag <= STATUS_RST[`CSF_BIT_CARRY];
    end else begin
      neg_flag <= next_neg;
      signed_wrap_flag <= next_wrap;
      zero_flag <= next_zero;
      carry_flag <= next_carry;
    end
  end

  // ****************************************
  // accumulator clip flags
  // ****************************************
  always @* begin
    next_clip_a = acc_a_clip_flag;
    next_clip_b = acc_b_clip_flag;
    if (wr_status) begin
      if (!wdata_i[`CSF_BIT_COMB_CLIP]) begin
        next_clip_a = wdata_i[`CSF_BIT_ACCA_CLIP];
        next_clip_b = wdata_i[`CSF_BIT_ACCB_CLIP];
      end else begin
        next_clip_a = wdata_i[`CSF_BIT_ACCA_CLIP] | acc_a_clip_flag;
        next_clip_b = wdata_i[`CSF_BIT_ACCB_CLIP] | acc_b_clip_flag;
      end
    end
    // hardware set wins over software clear
    if (clip_a_set_i) begin
      next_clip_a = 1'b1;
    end
    if (clip_b_set_i) begin
      next_clip_b = 1'b1;
    end
  end

  // ****************************************
  // clip flag state
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      acc_a_clip_flag <= STATUS_RST[`CSF_BIT_ACCA_CLIP];
      acc_b_clip_flag <= STATUS_RST[`CSF_BIT_ACCB_CLIP];
    end else begin
      acc_a_clip_flag <= next_clip_a;
      acc_b_clip_flag <= next_clip_b;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @* begin
    next_rdata = rdata_o;
    if (rd_i) begin
      if (field_sel(addr_i, `CSF_ADDR_STATUS)) begin
        next_rdata = status_word;
      end else if (field_sel(addr_i, `CSF_ADDR_CTRL)) begin
        next_rdata = core_control_reg;
      end else if (field_sel(addr_i, `CSF_ADDR_INTCON)) begin
        next_rdata = interrupt_control_one;
      end else begin
        next_rdata = `CSF_READ_NONE;
      end
    end
  end

  // ****************************************
  // read data state
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= `CSF_READ_NONE;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule // csf_status_flags

// file: tb_top.sv
// bench for the status flag block
`timescale 1ns/10ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] adr = 4'h0;
  reg [15:0] wd = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg go = 1'b0;
  reg [15:0] a = 16'h0000;
  reg [15:0] b = 16'h0000;
  reg sub = 1'b0;
  reg [3:0] aff = 4'h0;
  reg rep = 1'b0;
  reg ca = 1'b0;
  reg cb = 1'b0;
  reg pl = 1'b0;
  reg [2:0] plv = 3'h0;
  wire [15:0] rdat, res, st;
  wire vl, cy, as, bs, sb, irq;
  wire [3:0] upd, lvl;
  integer failures = 0;
  integer check_count = 0;
  integer i;
  // ****
  // clock, models, tasks
  // ****
  initial begin
    forever #20 clk = ~clk;
  end
  csf_alu_model csf_alu_model_inst (.clk_sys_i(clk), .go_i(go), .a_i(a), .b_i(b), .sub_i(sub), .aff_i(aff),
    .valid_o(vl), .result_o(res), .carry_o(cy), .a_sign_o(as), .b_sign_o(bs), .sub_o(sb), .upd_o(upd));
  csf_status_flags csf_status_flags_inst (.clk_sys_i(clk), .reset_i(rst), .addr_i(adr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .alu_valid_i(vl), .alu_result_i(res), .alu_carry_i(cy),
    .alu_a_sign_i(as), .alu_b_sign_i(bs), .alu_sub_i(sb), .upd_neg_i(upd[3]), .upd_wrap_i(upd[2]),
    .upd_zero_i(upd[1]), .upd_carry_i(upd[0]), .repeat_active_i(rep), .clip_a_set_i(ca), .clip_b_set_i(cb),
    .pri_load_i(pl), .pri_load_val_i(plv), .cpu_level_o(lvl), .user_irq_off_o(irq), .cpu_status_flags_o(st));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wrr(input [3:0] ad, input [15:0] d);
    begin
      @(posedge clk);
      adr <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
    end
  endtask
  task rdc(input [3:0] ad, input [15:0] e);
    begin
      @(posedge clk);
      adr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdat, e);
    end
  endtask
  task op(input [15:0] x, input [15:0] y, input s, input [3:0] f, input [3:0] e);
    begin
      @(posedge clk);
      a <= x;
      b <= y;
      sub <= s;
      aff <= f;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      @(negedge clk);
      chk({12'h000, st[3:0]}, {12'h000, e});
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    summarize;
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rdc(i[3:0], 16'h0000);
    end
    for (i = 0; i < 8; i = i + 1) begin
      wrr(4'h1, {12'h000, i[0], 3'h0});
      wrr(4'h0, {8'h00, i[2:0], 5'h00});
      chk({12'h000, lvl}, {12'h000, i[0], i[2:0]});
      chk({15'h0000, irq}, {15'h0000, i[2:0] == 3'h7});
    end
    wrr(4'h2, 16'h8000);
    wrr(4'h0, 16'h0020);
    rdc(4'h0, 16'h00E0);
    @(posedge clk);
    pl <= 1'b1;
    plv <= 3'h5;
    @(posedge clk);
    pl <= 1'b0;
    @(negedge clk);
    chk(st, 16'h00A0);
    chk({12'h000, lvl}, 16'h000D);
    wrr(4'h2, 16'h0000);
    wrr(4'h0, 16'h0000);
    rdc(4'h0, 16'h0000);
    $display("priority tests done");
    op(16'h7FFF, 16'h0001, 1'b0, 4'hF, 4'hC);
    op(16'h8000, 16'h0001, 1'b1, 4'hF, 4'h5);
    op(16'h0005, 16'h0005, 1'b1, 4'hF, 4'h3);
    op(16'h0001, 16'h0001, 1'b0, 4'h8, 4'h3);
    op(16'h0001, 16'h0001, 1'b0, 4'hF, 4'h0);
    @(posedge clk);
    rep <= 1'b1;
    rdc(4'h0, 16'h0010);
    @(posedge clk);
    rep <= 1'b0;
    rdc(4'h0, 16'h0000);
    $display("flag tests done");
    @(posedge clk);
    ca <= 1'b1;
    @(posedge clk);
    ca <= 1'b0;
    @(negedge clk);
    chk({13'h0000, st[11:9]}, 16'h0005);
    wrr(4'h0, 16'h0C00);
    chk({13'h0000, st[11:9]}, 16'h0007);
    wrr(4'h0, 16'h0000);
    chk({13'h0000, st[11:9]}, 16'h0000);
    @(posedge clk);
    cb <= 1'b1;
    @(posedge clk);
    cb <= 1'b0;
    @(negedge clk);
    chk({13'h0000, st[11:9]}, 16'h0003);
    wrr(4'h0, 16'h0A00);
    chk({13'h0000, st[11:9]}, 16'h0007);
    @(posedge clk);
    adr <= 4'h0;
    wd <= 16'h0000;
    wr <= 1'b1;
    ca <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    ca <= 1'b0;
    @(negedge clk);
    chk({13'h0000, st[11:9]}, 16'h0005);
    wrr(4'h0, 16'h0000);
    chk({13'h0000, st[11:9]}, 16'h0000);
    $display("clip tests done");
    summarize;
  end
endmodule // tb_top
